// [design/sic_pkg.sv]
// Constants and carrier types for the serial port interrupt/DMA control.
// Assumes the control, byte count and DMA words arrive as plain ports.
package sic_pkg;

  // Port control word bit positions
  localparam int CTL_ENABLE      = 0;   // Port enable
  localparam int CTL_WIRED_OR    = 4;   // Open-drain data outputs
  localparam int CTL_TIM         = 6;   // 1: transmit irq, 0: receive irq
  localparam int CTL_RX_FLUSH    = 12;  // Receive flush
  localparam int CTL_TX_SUPPRESS = 13;  // Transmit suppress
  localparam int CTL_MODE_LO     = 14;  // Irq mode field, low bit

  // Status word bit positions
  localparam int STA_IRQ         = 0;
  localparam int STA_UNDERRUN    = 4;
  localparam int STA_TX_IRQ      = 5;
  localparam int STA_RX_IRQ      = 6;
  localparam int STA_OVERFLOW    = 7;
  localparam int STA_LEVEL_LO    = 8;   // Receive FIFO level, three bits
  localparam int STA_SEL_ERR     = 12;

  // Reset values and counts
  localparam logic [15:0] STATUS_RESET  = 16'h0000;
  localparam logic [2:0]  LEVEL_RESET   = 3'h0;
  localparam logic [1:0]  TXCNT_RESET   = 2'h0;
  localparam logic [15:0] RXCNT_RESET   = 16'h0000;
  localparam logic [3:0]  BITS_PER_BYTE = 4'h8;
  localparam logic [3:0]  BITCNT_RESET  = 4'h0;

  // DMA request control word
  typedef struct packed {
    logic rx_req_en;   // Receive requests allowed
    logic tx_req_en;   // Transmit requests allowed
    logic enable;      // Master DMA enable
  } sic_dma_s;

  // Events from the shift engine, same clock domain
  typedef struct packed {
    logic xfer_start;  // A transfer begins
    logic tx_load;     // Byte moved from transmit FIFO to shifter
    logic rx_done;     // Received byte ready for the receive FIFO
    logic rx_read;     // Software popped one receive FIFO byte
  } sic_evt_s;

endpackage : sic_pkg

// [design/sic_ctrl.sv]
// Interrupt, chip-select error, open-drain and DMA request control.
// Assumes the shift engine and register file share i_core_clk; the
// serial clock and chip-select pins are asynchronous and synchronised.
`timescale 1ns/10ps
`default_nettype none

module sic_ctrl #(
  parameter int RX_DEPTH = 4   // Receive FIFO depth in bytes
) (
  input  wire logic            i_core_clk,
  input  wire logic            i_reset,
  input  wire logic [15:0]     i_port_control,    // Control word
  input  wire logic            i_control_wr,      // Control word written
  input  wire logic            i_status_rd,       // Status word read
  input  wire sic_pkg::sic_dma_s i_dma_control,   // DMA request control
  input  wire logic [15:0]     i_receive_byte_count, // Master rx count
  input  wire logic            i_byte_count_wr,   // Count written
  input  wire sic_pkg::sic_evt_s i_event,         // Shift engine events
  input  wire logic            i_tx_fifo_empty,   // Transmit FIFO empty
  input  wire logic            i_tx_fifo_full,    // Transmit FIFO full
  input  wire logic            i_serial_clk,      // Serial clock pin
  input  wire logic            i_select_n,        // Chip select pin
  input  wire logic            i_data_out,        // Serial data to send
  input  wire logic            i_data_drive,      // Engine drives data
  output logic [15:0]          o_port_status,     // Status word
  output logic                 o_irq,             // Interrupt line
  output logic                 o_dma_tx_req,      // Transmit DMA request
  output logic                 o_dma_rx_req,      // Receive DMA request
  output logic                 o_rx_count_done,   // Stop new transfers
  output logic                 o_data_pad,        // Data pad value
  output logic                 o_data_pad_oe      // Data pad enable
);

  // Whole module state, one register
  typedef struct packed {
    logic [1:0]  clk_sync;    // Serial clock synchroniser
    logic        clk_prev;    // Last synchronised serial clock
    logic [1:0]  sel_sync;    // Chip select synchroniser
    logic        sel_prev;    // Last synchronised chip select
    logic [3:0]  bit_cnt;     // Serial clocks within current byte
    logic [1:0]  tx_cnt;      // Transmitted bytes in this period
    logic [2:0]  rx_level;    // Receive FIFO occupancy
    logic [15:0] rx_cnt;      // Bytes received in master rx DMA
    logic        underrun;
    logic        tx_irq;
    logic        rx_irq;
    logic        overflow;
    logic        sel_err;
    logic [15:0] status;      // Registered status word
    logic        irq;
    logic        dma_tx_req;
    logic        dma_rx_req;
    logic        rx_done_cnt; // Byte count reached
    logic        pad;
    logic        pad_oe;
  } sic_state_s;

  sic_state_s state;       // Current state
  sic_state_s next_state;  // Next state

  // Control word fields
  logic       ctl_enable;
  logic       ctl_wired_or;
  logic       ctl_tim;
  logic       ctl_rx_flush;
  logic       ctl_tx_suppress;
  logic [1:0] ctl_mode;

  assign ctl_enable      = i_port_control[sic_pkg::CTL_ENABLE];
  assign ctl_wired_or    = i_port_control[sic_pkg::CTL_WIRED_OR];
  assign ctl_tim         = i_port_control[sic_pkg::CTL_TIM];
  assign ctl_rx_flush    = i_port_control[sic_pkg::CTL_RX_FLUSH];
  assign ctl_tx_suppress = i_port_control[sic_pkg::CTL_TX_SUPPRESS];
  assign ctl_mode = i_port_control[sic_pkg::CTL_MODE_LO +: 2];

  // Sticky flag update: a set in the clearing cycle survives the read
  function automatic logic flag_next(input logic cur, input logic set,
                                     input logic rd_clr,
                                     input logic hard_clr);
    if (hard_clr) begin
      flag_next = 1'b0;
    end else if (set) begin
      flag_next = 1'b1;
    end else if (rd_clr) begin
      flag_next = 1'b0;
    end else begin
      flag_next = cur;
    end
  endfunction : flag_next

  // Next state logic
  always_comb begin
    logic       dma_mode;
    logic       sclk_rise;
    logic       sel_fall;
    logic       sel_rise;
    logic       rx_full;
    logic       rx_store;
    logic       rx_ovf;
    logic       tx_period;
    logic       set_tx;
    logic       set_rx;
    logic [2:0] lvl;
    dma_mode  = 1'b0;
    sclk_rise = 1'b0;
    sel_fall  = 1'b0;
    sel_rise  = 1'b0;
    rx_full   = 1'b0;
    rx_store  = 1'b0;
    rx_ovf    = 1'b0;
    tx_period = 1'b0;
    set_tx    = 1'b0;
    set_rx    = 1'b0;
    lvl       = state.rx_level;
    next_state = state;

    // Pin synchronisers; only the second stage is looked at
    next_state.clk_sync = {state.clk_sync[0], i_serial_clk};
    next_state.sel_sync = {state.sel_sync[0], i_select_n};
    next_state.clk_prev = state.clk_sync[1];
    next_state.sel_prev = state.sel_sync[1];
    sclk_rise = state.clk_sync[1] & ~state.clk_prev;
    sel_fall  = ~state.sel_sync[1] & state.sel_prev;
    sel_rise  = state.sel_sync[1] & ~state.sel_prev;

    // DMA in use suppresses the count interrupts
    dma_mode = i_dma_control.enable
             & (i_dma_control.tx_req_en | i_dma_control.rx_req_en);

    // Serial clocks in the current byte; an early release is an error
    if (sel_fall) begin
      next_state.bit_cnt = sic_pkg::BITCNT_RESET;
    end else if (!state.sel_sync[1] && sclk_rise) begin
      if (state.bit_cnt == sic_pkg::BITS_PER_BYTE - 4'h1) begin
        next_state.bit_cnt = sic_pkg::BITCNT_RESET;
      end else begin
        next_state.bit_cnt = state.bit_cnt + 4'h1;
      end
    end
    next_state.sel_err = flag_next(state.sel_err,
      ctl_enable & sel_rise & (state.bit_cnt != sic_pkg::BITCNT_RESET),
      i_status_rd, ~ctl_enable);

    // Transmitted byte counter, restarted by a control write
    tx_period = i_event.tx_load & (state.tx_cnt == ctl_mode);
    if (i_control_wr) begin
      next_state.tx_cnt = sic_pkg::TXCNT_RESET;
    end else if (i_event.tx_load) begin
      // Counts bytes sent, never the FIFO level
      next_state.tx_cnt = tx_period ? sic_pkg::TXCNT_RESET
                                    : state.tx_cnt + 2'h1;
    end
    set_tx = tx_period & ~i_control_wr & ctl_tim & ~dma_mode
           & ~ctl_tx_suppress;
    next_state.tx_irq = flag_next(state.tx_irq, set_tx, i_status_rd,
      ~ctl_enable | ctl_tx_suppress);

    // Underrun: transfer start with nothing to send
    next_state.underrun = flag_next(state.underrun,
      ctl_enable & i_event.xfer_start & i_tx_fifo_empty
      & ~ctl_tx_suppress,
      i_status_rd, ~ctl_enable);

    // Receive FIFO level; flush holds it empty and stores nothing
    rx_full  = (state.rx_level == 3'(RX_DEPTH));
    rx_store = i_event.rx_done & ~rx_full & ~ctl_rx_flush;
    rx_ovf   = ctl_enable & i_event.rx_done & rx_full
             & ~ctl_rx_flush;
    if (ctl_rx_flush || !ctl_enable) begin
      lvl = sic_pkg::LEVEL_RESET;
    end else begin
      if (i_event.rx_read && state.rx_level != sic_pkg::LEVEL_RESET) begin
        lvl = lvl - 3'h1;
      end
      if (rx_store) begin
        lvl = lvl + 3'h1;
      end
    end
    next_state.rx_level = lvl;

    // Receive irq only on a FIFO write, against the level threshold
    set_rx = ctl_enable & rx_store & ~ctl_tim & ~dma_mode
           & ({1'b0, lvl} > {2'h0, ctl_mode});
    next_state.rx_irq = flag_next(state.rx_irq, set_rx, i_status_rd,
      ~ctl_enable | ctl_rx_flush);
    next_state.overflow = flag_next(state.overflow, rx_ovf, i_status_rd,
      ~ctl_enable);

    // Master receive byte counter
    if (!ctl_enable || i_byte_count_wr) begin
      next_state.rx_cnt = sic_pkg::RXCNT_RESET;
    end else if (i_event.rx_done && i_dma_control.enable
                 && i_dma_control.rx_req_en
                 && state.rx_cnt != i_receive_byte_count) begin
      next_state.rx_cnt = state.rx_cnt + 16'h0001;
    end
    // Count excludes the dummy read that started the transfer
    next_state.rx_done_cnt = i_dma_control.enable
      & i_dma_control.rx_req_en & ~i_byte_count_wr & ctl_enable
      & (next_state.rx_cnt == i_receive_byte_count);

    // DMA requests; clearing enable stops them, FIFO still drains
    next_state.dma_tx_req = ctl_enable & i_dma_control.enable
      & i_dma_control.tx_req_en & ~i_tx_fifo_full;
    next_state.dma_rx_req = ctl_enable & i_dma_control.enable
      & i_dma_control.rx_req_en & (lvl != sic_pkg::LEVEL_RESET);

    // Open-drain data: only ever pull low when wired-or is set
    if (ctl_wired_or) begin
      next_state.pad    = 1'b0;
      next_state.pad_oe = i_data_drive & ~i_data_out;
    end else begin
      next_state.pad    = i_data_out;
      next_state.pad_oe = i_data_drive;
    end

    // Interrupt line and status word mirror the next flags
    next_state.irq = next_state.underrun | next_state.tx_irq
                   | next_state.rx_irq | next_state.overflow
                   | next_state.sel_err;
    next_state.status = sic_pkg::STATUS_RESET;
    next_state.status[sic_pkg::STA_IRQ]      = next_state.irq;
    next_state.status[sic_pkg::STA_UNDERRUN] = next_state.underrun;
    next_state.status[sic_pkg::STA_TX_IRQ]   = next_state.tx_irq;
    next_state.status[sic_pkg::STA_RX_IRQ]   = next_state.rx_irq;
    next_state.status[sic_pkg::STA_OVERFLOW] = next_state.overflow;
    next_state.status[sic_pkg::STA_LEVEL_LO +: 3] = lvl;
    next_state.status[sic_pkg::STA_SEL_ERR]  = next_state.sel_err;
  end

  // State register; synchronous reset clears flags and counters
  always_ff @(posedge i_core_clk) begin
    if (i_reset) begin
      state          <= '0;
      state.clk_sync <= 2'h0;
      state.sel_sync <= 2'h3;   // Select idles high
      state.sel_prev <= 1'b1;
    end else begin
      state <= next_state;
    end
  end

  // Outputs straight from the state register
  assign o_port_status   = state.status;
  assign o_irq           = state.irq;
  assign o_dma_tx_req    = state.dma_tx_req;
  assign o_dma_rx_req    = state.dma_rx_req;
  assign o_rx_count_done = state.rx_done_cnt;
  assign o_data_pad      = state.pad;
  assign o_data_pad_oe   = state.pad_oe;

endmodule : sic_ctrl

`default_nettype wire

// [sim/sic_ctrl_properties.sv]
// Port-level checker for the serial port interrupt and DMA control.
// Assumes one clock domain and the synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module sic_ctrl_properties #(
  parameter int RX_DEPTH = 4  // Receive FIFO depth in bytes
) (
  input wire logic              i_core_clk,
  input wire logic              i_reset,
  input wire logic [15:0]       i_port_control,
  input wire logic              i_control_wr,
  input wire logic              i_status_rd,
  input wire sic_pkg::sic_dma_s i_dma_control,
  input wire sic_pkg::sic_evt_s i_event,
  input wire logic              i_tx_fifo_empty,
  input wire logic              i_tx_fifo_full,
  input wire logic              i_data_out,
  input wire logic              i_data_drive,
  input wire logic [15:0]       o_port_status,
  input wire logic              o_irq,
  input wire logic              o_dma_tx_req,
  input wire logic              o_data_pad,
  input wire logic              o_data_pad_oe
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_reset);
  // Count irqs are refused while any DMA direction is live
  wire logic dma_on = i_dma_control.enable
                    & (i_dma_control.tx_req_en | i_dma_control.rx_req_en);
  // A byte counted toward the transmit irq period
  sequence s_tx_byte;
    i_event.tx_load && i_port_control[6] && i_port_control[0]
      && !i_port_control[13] && !dma_on && !i_control_wr;
  endsequence
  // A status read with no competing set in the same cycle
  sequence s_quiet_read;
    i_status_rd && (i_event == '0);
  endsequence
  property p_irq_line;
    o_port_status[0] == o_irq
      && o_irq == |{o_port_status[12], o_port_status[7:4]};
  endproperty
  a_irq_line: assert property (p_irq_line) else $error("irq line");
  property p_tx_each;
    s_tx_byte ##0 (i_port_control[15:14] == 2'h0) |=> o_port_status[5];
  endproperty
  a_tx_each: assert property (p_tx_each) else $error("tx irq");
  property p_rx_tim;
    $rose(o_port_status[6]) |->
      !$past(i_port_control[6]) && $past(i_event.rx_done);
  endproperty
  a_rx_tim: assert property (p_rx_tim) else $error("rx irq cause");
  property p_read_clear;
    s_quiet_read |=> o_port_status[7:4] == 4'h0;
  endproperty
  a_read_clear: assert property (p_read_clear) else $error("read");
  property p_disable;
    !i_port_control[0] |=> o_port_status == 16'h0000 && !o_irq;
  endproperty
  a_disable: assert property (p_disable) else $error("disable");
  property p_underrun;
    i_event.xfer_start && i_tx_fifo_empty && i_port_control[0]
      && !i_port_control[13] |=> o_port_status[4] && o_irq;
  endproperty
  a_underrun: assert property (p_underrun) else $error("underrun");
  property p_overflow;
    i_event.rx_done && !i_event.rx_read && i_port_control[0]
      && !i_port_control[12] && o_port_status[10:8] == 3'(RX_DEPTH)
      |=> o_port_status[7];
  endproperty
  a_overflow: assert property (p_overflow) else $error("overflow");
  property p_dma_tx;
    i_port_control[0] && i_dma_control.enable && i_dma_control.tx_req_en
      && !i_tx_fifo_full |=> o_dma_tx_req;
  endproperty
  a_dma_tx: assert property (p_dma_tx) else $error("tx request");
  property p_wired_or;
    i_port_control[4] && i_data_drive && !i_data_out
      |=> o_data_pad_oe && !o_data_pad;
  endproperty
  a_wired_or: assert property (p_wired_or) else $error("open drain");
endmodule : sic_ctrl_properties
`default_nettype wire

// [sim/sic_far_master.sv]
// Far-side SPI master model: makes the serial clock and chip select.
// Assumes the testbench calls frame from its main sequence.
`timescale 1ns/10ps
`default_nettype none
module sic_far_master (
  output var logic o_sclk,   // Serial clock, idle low
  output var logic o_sel_n   // Chip select, active low
);
  // Clock stands still and select stays high outside frames
  initial begin
    o_sclk = 1'b0;
    o_sel_n = 1'b1;
  end
  // One frame of n clocks, 200 ns period; n from 1 to 7 is an early release
  task automatic frame(input int n);
    o_sel_n = 1'b0;
    #100;
    repeat (n) begin
      o_sclk = 1'b1;
      #100;
      o_sclk = 1'b0;
      #100;
    end
    o_sel_n = 1'b1;  // Release, then rest with select high
    #400;
  endtask : frame
endmodule : sic_far_master
`default_nettype wire

// [sim/tb.sv]
// Self-checking bench for the serial port interrupt and DMA control.
// Assumes inputs change at falling edges; far side is sic_far_master.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic              clk = 1'b0, rst = 1'b1, cwr = 1'b0, srd = 1'b0;
  logic              cntwr = 1'b0, tx_e = 1'b1, tx_f = 1'b0;
  logic              dout = 1'b0, drv = 1'b0;
  logic [15:0]       ctl = 16'h0000, cnt = 16'h0000, sta;
  logic              irq, txreq, rxreq, cdone, pad, oe, sclk, seln;
  sic_pkg::sic_dma_s dma = '0;
  sic_pkg::sic_evt_s evt = '0;
  int                err_count = 0, check_count = 0;
  // 40 MHz core clock
  always #12.5 clk = ~clk;
  sic_far_master sic_far_master_i (.o_sclk(sclk), .o_sel_n(seln));
  sic_ctrl sic_ctrl_i (.i_core_clk(clk), .i_reset(rst),
    .i_port_control(ctl), .i_control_wr(cwr), .i_status_rd(srd),
    .i_dma_control(dma), .i_receive_byte_count(cnt),
    .i_byte_count_wr(cntwr), .i_event(evt), .i_tx_fifo_empty(tx_e),
    .i_tx_fifo_full(tx_f), .i_serial_clk(sclk), .i_select_n(seln),
    .i_data_out(dout), .i_data_drive(drv), .o_port_status(sta),
    .o_irq(irq), .o_dma_tx_req(txreq), .o_dma_rx_req(rxreq),
    .o_rx_count_done(cdone), .o_data_pad(pad), .o_data_pad_oe(oe));
  task automatic summarize;
    $display("checks %0d errors %0d", check_count, err_count);
    if (err_count == 0 && check_count > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : summarize
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask : tick
  // One-cycle event pulse, then a settle cycle before checking
  task automatic ev(input sic_pkg::sic_evt_s e);
    @(negedge clk);
    evt = e;
    @(negedge clk);
    evt = '0;
    tick(1);
  endtask : ev
  task automatic wctl(input logic [15:0] v);
    @(negedge clk);
    ctl = v;
    cwr = 1'b1;
    @(negedge clk);
    cwr = 1'b0;
    tick(1);
  endtask : wctl
  task automatic rd;
    @(negedge clk);
    srd = 1'b1;
    @(negedge clk);
    srd = 1'b0;
    tick(1);
  endtask : rd
  // Transmit period for every mode, counter restart, suppress
  task automatic t_tx;
    for (int m = 0; m < 4; m++) begin
      wctl({m[1:0], 14'h0041});
      repeat (m) ev(4'h4);
      chk(sta, 16'h0000);
      ev(4'h4);
      chk(sta, 16'h0021);
      rd;
      chk(sta, 16'h0000);
    end
    repeat (3) ev(4'h4);
    wctl(16'hC041);
    repeat (3) ev(4'h4);
    chk(sta, 16'h0000);
    ev(4'h4);
    chk(sta, 16'h0021);
    rd;
    wctl(16'h2041);
    ev(4'h4);
    ev(4'h8);
    chk(sta, 16'h0000);
  endtask : t_tx
  // Underrun in receive-irq mode with the largest mode code
  task automatic t_under;
    wctl(16'hC001);
    ev(4'h8);
    chk(sta, 16'h0011);
    chk({15'h0, irq}, 16'h0001);
    rd;
    chk(sta, 16'h0000);
    // Receive-irq mode: a full transmit period raises nothing
    repeat (4) ev(4'h4);
    chk(sta, 16'h0000);
    // A start with data waiting is no underrun
    tx_e = 1'b0;
    ev(4'h8);
    chk(sta, 16'h0000);
    tx_e = 1'b1;
  endtask : t_under
  // Receive threshold, fill to overflow, flush, disable
  task automatic t_rx;
    wctl(16'h4001);
    ev(4'h2);
    chk(sta, 16'h0100);
    ev(4'h2);
    chk(sta, 16'h0241);
    rd;
    chk(sta, 16'h0200);
    repeat (2) ev(4'h2);
    chk(sta, 16'h0441);
    ev(4'h2);
    chk(sta, 16'h04C1);
    // A pop lowers the level but never raises the receive irq
    ev(4'h1);
    chk(sta, 16'h03C1);
    // Flush empties the FIFO and drops the receive irq, overflow stays
    wctl(16'h5001); // Flush after overflow
    chk(sta, 16'h0081);
    rd;
    ev(4'h2);
    chk(sta, 16'h0000);
    wctl(16'h0000);
    chk(sta, 16'h0000);
  endtask : t_rx
  // Early select release against a full byte
  task automatic t_select_error_flag;
    wctl(16'h0001);
    sic_far_master_i.frame(3);
    for (int i = 0; i < 40 && sta[12] !== 1'b1; i++) tick(1);
    chk(sta, 16'h1001);
    if (sta[12] !== 1'b1) summarize;
    wctl(16'h0000);
    wctl(16'h0001);
    sic_far_master_i.frame(8);
    tick(10);
    chk(sta, 16'h0000);
  endtask : t_select_error_flag
  // DMA requests, count irq refusal, master receive byte count
  task automatic t_dma;
    wctl(16'h0041);
    dma = 3'b011;
    tick(2);
    chk({15'h0, txreq}, 16'h0001);
    tx_f = 1'b1;
    ev(4'h4);
    chk({sta[15:1], txreq}, 16'h0000);
    ev(4'h8);
    chk(sta, 16'h0011);
    rd;
    dma = 3'b010;
    tx_f = 1'b0;
    tick(2);
    chk({15'h0, txreq}, 16'h0000);
    dma = 3'b101;
    cnt = 16'h0002;
    cntwr = 1'b1;
    tick(1);
    cntwr = 1'b0;
    ev(4'h1); // Dummy read starts the master receive
    ev(4'h2);
    chk({13'h0, cdone, rxreq, txreq}, 16'h0002);
    ev(4'h2);
    chk({13'h0, cdone, rxreq, txreq}, 16'h0006);
    cntwr = 1'b1;
    tick(1);
    cntwr = 1'b0;
    tick(2);
    chk({15'h0, cdone}, 16'h0000);
    dma = 3'b000;
    wctl(16'h0000);
  endtask : t_dma
  // Pad drive with and without the wired-or bit
  task automatic t_pad;
    wctl(16'h0011);
    drv = 1'b1;
    tick(2);
    chk({14'h0, pad, oe}, 16'h0001);
    dout = 1'b1;
    tick(2);
    chk({14'h0, pad, oe}, 16'h0000);
    wctl(16'h0001);
    chk({14'h0, pad, oe}, 16'h0003);
  endtask : t_pad
  initial begin
    tick(16);
    rst = 1'b0;
    tick(1);
    chk(sta, 16'h0000);
    t_tx;
    t_under;
    t_rx;
    t_select_error_flag;
    t_dma;
    t_pad;
    summarize;
  end
endmodule : tb
bind sic_ctrl sic_ctrl_properties #(.RX_DEPTH(RX_DEPTH))
  sic_ctrl_properties_i (.i_core_clk, .i_reset, .i_port_control,
  .i_control_wr, .i_status_rd, .i_dma_control, .i_event,
  .i_tx_fifo_empty, .i_tx_fifo_full, .i_data_out, .i_data_drive,
  .o_port_status, .o_irq, .o_dma_tx_req, .o_data_pad, .o_data_pad_oe);
`default_nettype wire
